// ### include/dio_map.svh
// Notes on behaviour
// - direction bit set means output, clear input
// - direction mask resets to zero, all inputs
// - per-port drive style, push-pull after reset
// - port selector resets zero, must be zero; a 1 is still stored, and direction and style are then left unchanged
// - shared level select, five choices, default highest
// - switch for two-wire bus pull-ups
// - global time limit in ms, reset 30000
// - port read returns pin or driven level
// - port write touches only output lines
// - line write drives selected output high/low
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH
`define DIO_DIR_RESET      8'h00
`define DIO_OUT_RESET      8'h00
`define DIO_PORT_RESET     1'b0
`define DIO_PULLUP_RESET   1'b0
`define DIO_LIMIT_RESET    32'h0000_7530
`define DIO_MS_CYCLES      32'h0003_0d40
`define DIO_RST_SYNC_RESET 2'h0
`define DIO_STYLE_RESET    1'b0
`define DIO_LEVEL_RESET    3'h0
`define DIO_LEVEL_MAX      3'h4
`define DIO_PIN_RESET      8'h00
`define DIO_OE_RESET       8'h00
`define DIO_READ_RESET     8'h00
`define DIO_CYCLES_RESET   32'h0000_0000
`endif

// ### include/dio_pkg.sv
package dio_pkg;
  typedef enum logic [0:0] {
    DIO_PUSH_PULL  = 1'b0,
    DIO_OPEN_DRAIN = 1'b1
  } dio_style_t;
  typedef enum logic [2:0] {
    DIO_LVL_3V3 = 3'b000,
    DIO_LVL_2V5 = 3'b001,
    DIO_LVL_1V8 = 3'b010,
    DIO_LVL_1V5 = 3'b011,
    DIO_LVL_1V2 = 3'b100
  } dio_level_t;
endpackage : dio_pkg

// ### rtl/dio_port_config.sv
`timescale 1ns/1ps
`include "dio_map.svh"
module dio_port_config (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // configuration writes
  input  wire logic       CFG_WE,
  input  wire logic       CFG_PORT,
  input  wire logic [7:0] CFG_DIR,
  input  wire logic       CFG_STYLE,
  input  wire logic [2:0] CFG_LEVEL,
  input  wire logic       CFG_PULLUP,
  input  wire logic       LIMIT_WE,
  input  wire logic [31:0] LIMIT_VAL,
  // data writes
  input  wire logic       PORT_WE,
  input  wire logic [7:0] PORT_VAL,
  input  wire logic       LINE_WE,
  input  wire logic [2:0] LINE_SEL,
  input  wire logic       LINE_VAL,
  // pins
  input  wire logic [7:0] PIN_I,
  output logic [7:0]      PIN_O,
  output logic [7:0]      PIN_OE,
  // status
  output logic [7:0]      PORT_READ,
  output logic [7:0]      LINE_DIRECTION_MASK,
  output logic            OUTPUT_DRIVE_STYLE,
  output logic            SELECTED_PORT_INDEX,
  output logic [2:0]      IO_LEVEL,
  output logic            PULLUP_EN,
  output logic [31:0]     OPERATION_TIME_LIMIT,
  output logic [31:0]     LIMIT_CYCLES
);
  // reset release
  logic [1:0]  rst_sync_r;
  logic [1:0]  rst_sync_nxt;
  logic        rst_n;
  // configuration
  logic [7:0]  dir_r;
  logic [7:0]  dir_nxt;
  logic        style_r;
  logic        style_nxt;
  logic        port_r;
  logic        port_nxt;
  logic [2:0]  lvl_r;
  logic [2:0]  lvl_nxt;
  logic        pull_r;
  logic        pull_nxt;
  // output latch
  logic [7:0]  out_r;
  logic [7:0]  out_nxt;
  // pin drive and readback
  logic [7:0]  pin_o_r;
  logic [7:0]  pin_o_nxt;
  logic [7:0]  oe_r;
  logic [7:0]  oe_nxt;
  logic [7:0]  rd_r;
  logic [7:0]  rd_nxt;
  // time limit
  logic [31:0] lim_r;
  logic [31:0] lim_nxt;
  logic [31:0] cyc_r;
  logic [31:0] cyc_nxt;
  logic [63:0] cyc_full;

  // steps of the checked behaviour
  sequence s_port_write;
    PORT_WE && !LINE_WE;
  endsequence
  sequence s_port_then_pp;
    s_port_write ##1 (style_r == dio_pkg::DIO_PUSH_PULL);
  endsequence
  sequence s_line_write;
    LINE_WE && dir_r[LINE_SEL];
  endsequence
  sequence s_line_refused;
    LINE_WE && !dir_r[LINE_SEL] && !PORT_WE;
  endsequence
  sequence s_cfg_home;
    CFG_WE && !CFG_PORT;
  endsequence
  sequence s_cfg_absent;
    CFG_WE && CFG_PORT;
  endsequence
  sequence s_level_refused;
    CFG_WE && (CFG_LEVEL > `DIO_LEVEL_MAX);
  endsequence

  // the pin reset asserts at once but releases on a clock edge, two flops deep
  always_comb begin
    rst_sync_nxt = {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) rst_sync_r <= `DIO_RST_SYNC_RESET;
    else rst_sync_r <= rst_sync_nxt;
  end
  assign rst_n = rst_sync_r[1];

  always_comb begin
    dir_nxt   = dir_r;
    style_nxt = style_r;
    port_nxt  = port_r;
    lvl_nxt   = lvl_r;
    pull_nxt  = pull_r;
    if (CFG_WE) begin
      port_nxt = CFG_PORT;
      // only port 0 exists; direction and style writes aimed elsewhere are ignored, selector, level and pull-up still load
      if (CFG_PORT == 1'b0) begin
        dir_nxt   = CFG_DIR;
        style_nxt = CFG_STYLE;
      end
      // unknown level codes keep the old level so the pins never see an undefined supply
      if (CFG_LEVEL <= `DIO_LEVEL_MAX) lvl_nxt = CFG_LEVEL;
      pull_nxt = CFG_PULLUP;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dir_r   <= `DIO_DIR_RESET;
      style_r <= `DIO_STYLE_RESET;
      port_r  <= `DIO_PORT_RESET;
      lvl_r   <= `DIO_LEVEL_RESET;
      pull_r  <= `DIO_PULLUP_RESET;
    end else begin
      dir_r   <= dir_nxt;
      style_r <= style_nxt;
      port_r  <= port_nxt;
      lvl_r   <= lvl_nxt;
      pull_r  <= pull_nxt;
    end
  end

  chk_cfg_load: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_cfg_home |=> (LINE_DIRECTION_MASK == $past(CFG_DIR)) && (OUTPUT_DRIVE_STYLE == $past(CFG_STYLE)))
    else $error("port configuration not loaded");
  chk_bad_port: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_cfg_absent |=> $stable(dir_r) && $stable(style_r))
    else $error("configuration changed for absent port");
  chk_selector_store: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    CFG_WE |=> SELECTED_PORT_INDEX == $past(CFG_PORT))
    else $error("port selector not stored");
  chk_level_legal: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    IO_LEVEL <= `DIO_LEVEL_MAX)
    else $error("illegal level");
  chk_level_keep: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_level_refused |=> $stable(IO_LEVEL))
    else $error("refused level code applied");
  chk_pullup_load: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    CFG_WE |=> PULLUP_EN == $past(CFG_PULLUP))
    else $error("pull-up switch not loaded");

  // a line write in the same cycle lands on top of the port write
  always_comb begin
    out_nxt = out_r;
    if (PORT_WE) out_nxt = (out_r & ~dir_r) | (PORT_VAL & dir_r);
    if (LINE_WE && dir_r[LINE_SEL]) out_nxt[LINE_SEL] = LINE_VAL;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) out_r <= `DIO_OUT_RESET;
    else out_r <= out_nxt;
  end

  chk_port_write_mask: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_port_write |=> ((out_r ^ $past(out_r)) & ~$past(dir_r)) == 8'h00)
    else $error("input line latch changed");
  chk_line_write: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_line_write |=> out_r[$past(LINE_SEL)] == $past(LINE_VAL))
    else $error("line write lost");
  chk_line_ignored: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_line_refused |=> $stable(out_r))
    else $error("line write landed on input line");

  // pins and readback are registered, so they lag the latch by one cycle
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (style_r == dio_pkg::DIO_OPEN_DRAIN) begin
        pin_o_nxt[i] = 1'b0;
        oe_nxt[i]    = dir_r[i] & ~out_r[i];
      end else begin
        pin_o_nxt[i] = out_r[i];
        oe_nxt[i]    = dir_r[i];
      end
    end
    rd_nxt = (dir_r & out_r) | (~dir_r & PIN_I);
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_r <= `DIO_PIN_RESET;
      oe_r    <= `DIO_OE_RESET;
      rd_r    <= `DIO_READ_RESET;
    end else begin
      pin_o_r <= pin_o_nxt;
      oe_r    <= oe_nxt;
      rd_r    <= rd_nxt;
    end
  end

  chk_input_no_drive: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    (PIN_OE & ~$past(dir_r)) == 8'h00)
    else $error("input line driven");
  chk_push_pull_drive: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    (style_r == dio_pkg::DIO_PUSH_PULL) |=> (PIN_OE == $past(dir_r)) && (PIN_O == $past(out_r)))
    else $error("push-pull pins do not follow latch");
  chk_od_low_only: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    (style_r == dio_pkg::DIO_OPEN_DRAIN) |=> (PIN_O == 8'h00))
    else $error("open drain drove high");
  chk_od_release: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    (style_r == dio_pkg::DIO_OPEN_DRAIN) |=> PIN_OE == ($past(dir_r) & ~$past(out_r)))
    else $error("open drain did not release high line");
  chk_port_to_pin: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    s_port_then_pp |=> (PIN_O & $past(dir_r, 2)) == ($past(PORT_VAL, 2) & $past(dir_r, 2)))
    else $error("port write did not reach pins");
  chk_read_back: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    1'b1 |=> PORT_READ == (($past(dir_r) & $past(out_r)) | (~$past(dir_r) & $past(PIN_I))))
    else $error("read mismatch");

  // the cycle count is reported only; it wraps for limits above about 21 s
  always_comb begin
    lim_nxt = lim_r;
    if (LIMIT_WE) lim_nxt = LIMIT_VAL;
    cyc_full = 64'(lim_r) * 64'(`DIO_MS_CYCLES);
    cyc_nxt  = cyc_full[31:0];
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lim_r <= `DIO_LIMIT_RESET;
      cyc_r <= `DIO_CYCLES_RESET;
    end else begin
      lim_r <= lim_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  chk_limit_load: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    LIMIT_WE |=> OPERATION_TIME_LIMIT == $past(LIMIT_VAL))
    else $error("limit not loaded");
  chk_cycles_track: assert property (@(posedge CLK) disable iff (!RESETN || !rst_n)
    1'b1 |=> LIMIT_CYCLES == 32'($past(lim_r) * `DIO_MS_CYCLES))
    else $error("limit cycle count wrong");

  assign PIN_O                = pin_o_r;
  assign PIN_OE               = oe_r;
  assign PORT_READ            = rd_r;
  assign LINE_DIRECTION_MASK  = dir_r;
  assign OUTPUT_DRIVE_STYLE   = style_r;
  assign SELECTED_PORT_INDEX  = port_r;
  assign IO_LEVEL             = lvl_r;
  assign PULLUP_EN            = pull_r;
  assign OPERATION_TIME_LIMIT = lim_r;
  assign LIMIT_CYCLES         = cyc_r;
endmodule : dio_port_config

// ### testbench/dio_ext_model.sv
`timescale 1ns/1ps
module dio_ext_model (
  // board side of the port
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_oe,
  output logic [7:0]      pin_i
);
  // released lines float high on the board pull-up
  always_comb begin
    for (int n = 0; n < 8; n++) pin_i[n] = pin_oe[n] ? pin_o[n] : (ext_oe[n] ? ext_val[n] : 1'b1);
  end
endmodule : dio_ext_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic CLK = 0, RESETN = 0, CFG_WE = 0, CFG_PORT = 0, CFG_STYLE = 0, CFG_PULLUP = 0;
  logic LIMIT_WE = 0, PORT_WE = 0, LINE_WE = 0, LINE_VAL = 0, OUTPUT_DRIVE_STYLE, SELECTED_PORT_INDEX, PULLUP_EN;
  logic [7:0] CFG_DIR = 8'h00, PORT_VAL = 8'h00, PIN_I, PIN_O, PIN_OE, PORT_READ, LINE_DIRECTION_MASK;
  logic [7:0] ext_val = 8'h5a, ext_oe = 8'hf0;
  logic [2:0] CFG_LEVEL = 3'h0, LINE_SEL = 3'h0, IO_LEVEL;
  logic [31:0] LIMIT_VAL = 32'h0, OPERATION_TIME_LIMIT, LIMIT_CYCLES;
  int err_total = 0, comparisons = 0;
  always #2.5 CLK = ~CLK;
  dio_port_config u_dio_port_config (.CLK, .RESETN, .CFG_WE, .CFG_PORT, .CFG_DIR, .CFG_STYLE, .CFG_LEVEL,
    .CFG_PULLUP, .LIMIT_WE, .LIMIT_VAL, .PORT_WE, .PORT_VAL, .LINE_WE, .LINE_SEL, .LINE_VAL, .PIN_I, .PIN_O,
    .PIN_OE, .PORT_READ, .LINE_DIRECTION_MASK, .OUTPUT_DRIVE_STYLE, .SELECTED_PORT_INDEX, .IO_LEVEL,
    .PULLUP_EN, .OPERATION_TIME_LIMIT, .LIMIT_CYCLES);
  dio_ext_model u_dio_ext_model (.pin_o(PIN_O), .pin_oe(PIN_OE), .ext_val, .ext_oe, .pin_i(PIN_I));
  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // strobes are one cycle wide; three settle cycles cover the two-cycle pin latency
  task cfg(input logic p, input logic [7:0] d, input logic s, input logic [2:0] l, input logic u);
    {CFG_PORT, CFG_DIR, CFG_STYLE, CFG_LEVEL, CFG_PULLUP, CFG_WE} = {p, d, s, l, u, 1'b1};
    cyc(1);
    CFG_WE = 0;
    cyc(3);
  endtask : cfg
  task pw(input logic [7:0] v);
    {PORT_VAL, PORT_WE} = {v, 1'b1};
    cyc(1);
    PORT_WE = 0;
    cyc(3);
  endtask : pw
  task lw(input logic [2:0] s, input logic v);
    {LINE_SEL, LINE_VAL, LINE_WE} = {s, v, 1'b1};
    cyc(1);
    LINE_WE = 0;
    cyc(3);
  endtask : lw
  task t_reset;
    chk(LINE_DIRECTION_MASK, 8'h00);
    chk(PIN_OE, 8'h00);
    chk(OUTPUT_DRIVE_STYLE, 1'b0);
    chk(SELECTED_PORT_INDEX, 1'b0);
    chk(IO_LEVEL, 3'h0);
    chk(OPERATION_TIME_LIMIT, 32'h0000_7530);
    chk(LIMIT_CYCLES, 32'h65a0_bc00);
    chk(PIN_O, 8'h00);
    chk(PULLUP_EN, 1'b0);
  endtask : t_reset
  task t_rereset;
    RESETN = 0;
    cyc(2);
    chk(LINE_DIRECTION_MASK, 8'h00);
    RESETN = 1;
    cyc(4);
    t_reset();
  endtask : t_rereset
  task t_port;
    cfg(1'b0, 8'h0f, 1'b0, 3'h0, 1'b0);
    pw(8'hff);
    chk(PIN_OE, 8'h0f);
    chk(PIN_O & 8'h0f, 8'h0f);
    chk(PORT_READ, 8'h5f);
    lw(3'h2, 1'b0);
    chk(PIN_O & 8'h0f, 8'h0b);
    lw(3'h2, 1'b1);
    lw(3'h6, 1'b0);
    chk(PORT_READ, 8'h5f);
  endtask : t_port
  task t_drain;
    cfg(1'b0, 8'h0f, 1'b1, 3'h0, 1'b0);
    pw(8'h05);
    chk(OUTPUT_DRIVE_STYLE, 1'b1);
    chk(PIN_OE, 8'h0a);
    chk(PIN_O, 8'h00);
    chk(PORT_READ, 8'h55);
  endtask : t_drain
  task t_levels;
    for (int lv = 0; lv < 5; lv++) begin
      cfg(1'b0, 8'h0f, 1'b1, lv[2:0], lv[0]);
      chk(IO_LEVEL, lv[2:0]);
      chk(PULLUP_EN, lv[0]);
    end
    cfg(1'b0, 8'h0f, 1'b1, 3'h5, 1'b1);
    chk(IO_LEVEL, 3'h4);
    chk(PULLUP_EN, 1'b1);
  endtask : t_levels
  task t_select;
    cfg(1'b1, 8'hff, 1'b0, 3'h0, 1'b0);
    chk(SELECTED_PORT_INDEX, 1'b1);
    chk(LINE_DIRECTION_MASK, 8'h0f);
    chk(OUTPUT_DRIVE_STYLE, 1'b1);
    cfg(1'b0, 8'h0f, 1'b1, 3'h0, 1'b0);
  endtask : t_select
  task t_limit;
    {LIMIT_VAL, LIMIT_WE} = {32'h0000_0002, 1'b1};
    cyc(1);
    LIMIT_WE = 0;
    cyc(1);
    chk(OPERATION_TIME_LIMIT, 32'h0000_0002);
    chk(LIMIT_CYCLES, 32'h0006_1a80);
  endtask : t_limit
  task print_verdict;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(10);
    RESETN = 1;
    cyc(4);
    t_reset();
    t_port();
    t_drain();
    t_levels();
    t_select();
    t_limit();
    t_rereset();
    print_verdict();
  end
endmodule : testbench
